// file: logic/i2crp_dev.sv
// Behaviour
// - base address register, reset default 1011000b
// - straps set base bits zero and one
// - optional gpio level sets bit two
// - straps held static during operation
// - respond only to matching base address
// - short or long offset mode selectable
// - all offset bits address registers
// - short: page byte high, offset low
// - page register at offset fc, burst
// - long: two offset bytes form address
// - long: page register at fffc, burst
// - multi-byte registers in one burst
// - short burst must not pass ff
// - pointer increments after each data byte
// - works at 100k, 400k, 1M clock
// - read uses offset write, repeated start
// - accept access only after configuration
// - 64K space, user registers upper half
//
// Design decision made here: the Avalon-MM slave port.
`include "i2crp_regs.svh"
`default_nettype none
module i2crp_dev
	import i2crp_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// serial link
	i2crp_if.dev             bus,
	// configuration and straps
	input  wire logic        cfg_done,
	input  wire logic        cfg_base_load,
	input  wire logic [6:0]  cfg_base,
	input  wire logic        long_offset_mode,
	input  wire logic        gpio_strap_en,
	input  wire logic        strap_addr_bit_zero,
	input  wire logic        strap_addr_bit_one,
	input  wire logic        gpio_addr_bit_two,
	// register side
	output var  logic [15:0] reg_addr,
	output var  logic [7:0]  reg_wdata,
	output var  logic        reg_wr,
	output var  logic        reg_rd,
	input  wire logic [7:0]  reg_rdata,
	output var  logic        reg_commit,
	output var  logic [31:0] port_page_select
);
	// ==========================================================
	// synchronisers and edge detection
	logic          scl_s, sda_s, s0_s, s1_s, g2_s;
	logic          scl_q, sda_q;
	logic          rise, fall, st, sp;

	i2crp_sync #(.W(5), .INIT(5'h1f)) u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.d       ({bus.scl, bus.sda, strap_addr_bit_zero, strap_addr_bit_one,
		           gpio_addr_bit_two}),
		.q       ({scl_s, sda_s, s0_s, s1_s, g2_s})
	);

	// previous levels for edges
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	assign rise = scl_s && !scl_q;
	assign fall = !scl_s && scl_q;
	assign st   = scl_s && scl_q && sda_q && !sda_s;  // start or repeated start
	assign sp   = scl_s && scl_q && !sda_q && sda_s;  // stop

	// ==========================================================
	// base address
	logic [6:0]    base_r;
	logic          g2_r;
	logic [1:0]    wait_r;
	logic [6:0]    dev_base;

	always_ff @(posedge clk) begin
		if (sys_rst)
			base_r <= `I2CRP_DEF_BASE;
		else if (cfg_base_load)
			base_r <= cfg_base;
	end

	// gpio level caught after reset, once synchroniser has settled
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wait_r <= 2'h0;
			g2_r   <= 1'b0;
		end else if (wait_r != `I2CRP_WAIT_CAP) begin
			wait_r <= wait_r + 2'h1;
			if (wait_r == `I2CRP_WAIT_CAP - 2'h1)
				g2_r <= g2_s;
		end
	end

	// straps override low bits; they are trusted static
	assign dev_base = {base_r[6:3], gpio_strap_en ? g2_r : base_r[2], s1_s, s0_s};

	// ==========================================================
	// byte engine
	i2crp_dphase_t phase_r;
	logic [3:0]    bcnt_r;
	logic [7:0]    sh_r, tx_r;
	logic [15:0]   ptr_r;
	logic          oe_r, rd_req_r, rd_cap_r, wrote_r;
	logic [23:0]   stage_r;
	logic          active, byte_done;

	// page register decode follows the offset mode
	function automatic logic pg_hit(input logic [15:0] a, input logic lm);
		// the offset constant doubles as its own mask, its low two bits are clear
		pg_hit = lm ? ((a & `I2CRP_PG_OFS_L) == `I2CRP_PG_OFS_L)
		            : ((a[7:0] & `I2CRP_PG_OFS_S) == `I2CRP_PG_OFS_S);
	endfunction : pg_hit

	assign active    = (phase_r != DP_IDLE) && (phase_r != DP_IGN);
	assign byte_done = fall && active && (bcnt_r == 4'h8);

	// protocol state, pointer and data line
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			phase_r  <= DP_IDLE;
			bcnt_r   <= 4'h0;
			sh_r     <= 8'h00;
			ptr_r    <= 16'h0000;
			oe_r     <= 1'b0;
			rd_req_r <= 1'b0;
		end else begin
			rd_req_r <= 1'b0;
			if (st) begin
				phase_r <= DP_ADDR;
				bcnt_r  <= 4'h0;
				oe_r    <= 1'b0;
			end else if (sp) begin
				phase_r <= DP_IDLE;
				oe_r    <= 1'b0;
			end else if (phase_r == DP_IGN) begin
				oe_r <= 1'b0;
			end else if (rise && active && bcnt_r != 4'h9) begin
				bcnt_r <= bcnt_r + 4'h1;
				if (bcnt_r != 4'h8)
					sh_r <= {sh_r[6:0], sda_s};
				else if (phase_r == DP_RD && sda_s)
					phase_r <= DP_IGN;  // controller declined more data
			end else if (byte_done) begin
				oe_r <= 1'b1;
				unique case (phase_r)
					DP_ADDR: begin
						if (sh_r[7:1] == dev_base && cfg_done) begin
							if (sh_r[0]) begin
								phase_r  <= DP_RD;
								rd_req_r <= 1'b1;
							end else begin
								phase_r <= long_offset_mode ? DP_OFFH : DP_OFFL;
							end
						end else begin
							phase_r <= DP_IGN;
							oe_r    <= 1'b0;
						end
					end
					DP_OFFH: begin
						ptr_r[15:8] <= sh_r;
						phase_r     <= DP_OFFL;
					end
					DP_OFFL: begin
						// short mode takes the page byte
						ptr_r   <= {long_offset_mode ? ptr_r[15:8] : port_page_select[15:8],
						            sh_r};
						phase_r <= DP_WR;
					end
					DP_WR: begin
						ptr_r <= ptr_r + 16'h0001;
					end
					DP_RD: begin
						// advance after read, controller owns ack slot
						oe_r     <= 1'b0;
						ptr_r    <= ptr_r + 16'h0001;
						rd_req_r <= 1'b1;
					end
					default: ;
				endcase
			end else if (fall && active && bcnt_r == 4'h9) begin
				bcnt_r <= 4'h0;
				oe_r   <= (phase_r == DP_RD) ? !tx_r[7] : 1'b0;
			end else if (fall && phase_r == DP_RD && bcnt_r != 4'h0) begin
				oe_r <= !tx_r[3'(4'h7 - bcnt_r)];
			end
		end
	end

	// ==========================================================
	// register side strobes
	// fetch runs ahead of the bit clock, well inside one low phase
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_addr  <= 16'h0000;
			reg_wdata <= 8'h00;
			reg_wr    <= 1'b0;
			reg_rd    <= 1'b0;
			rd_cap_r  <= 1'b0;
		end else begin
			reg_wr   <= 1'b0;
			reg_rd   <= rd_req_r;
			rd_cap_r <= reg_rd;
			if (rd_req_r)
				reg_addr <= ptr_r;
			// only upper-half writes reach the register side; reads strobe any address
			if (byte_done && phase_r == DP_WR && !pg_hit(ptr_r, long_offset_mode)
			    && ptr_r[`I2CRP_USER_BIT]) begin
				reg_addr  <= ptr_r;
				reg_wdata <= sh_r;
				reg_wr    <= 1'b1;
			end
		end
	end

	// read data: page register, user space or zero
	always_ff @(posedge clk) begin
		if (sys_rst)
			tx_r <= 8'h00;
		else if (rd_cap_r) begin
			if (pg_hit(reg_addr, long_offset_mode))
				tx_r <= port_page_select[8*reg_addr[1:0] +: 8];
			else
				tx_r <= reg_addr[`I2CRP_USER_BIT] ? reg_rdata : 8'h00;
		end
	end

	// page bytes staged, whole word lands with the last byte
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			stage_r          <= 24'h000000;
			port_page_select <= 32'h00000000;
		end else if (byte_done && phase_r == DP_WR && pg_hit(ptr_r, long_offset_mode)) begin
			if (ptr_r[1:0] == 2'h3)
				port_page_select <= {sh_r, stage_r};
			else
				stage_r[8*ptr_r[1:0] +: 8] <= sh_r;
		end
	end

	// burst end tells the register side to apply staged bytes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wrote_r    <= 1'b0;
			reg_commit <= 1'b0;
		end else begin
			reg_commit <= (st || sp) && wrote_r;
			// a write landing with the frame edge wins, no byte goes unapplied
			if (reg_wr)
				wrote_r <= 1'b1;
			else if (st || sp)
				wrote_r <= 1'b0;
		end
	end

	// open drain: only ever pulls low
	assign bus.sda_s_o  = 1'b0;
	assign bus.sda_s_oe = oe_r;
endmodule : i2crp_dev
`default_nettype wire

// file: logic/i2crp_host.sv
`include "i2crp_regs.svh"
`default_nettype none
module i2crp_host
	import i2crp_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// serial link
	i2crp_if.host            bus,
	// avalon-mm slave
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output var  logic [31:0] readdata,
	output logic             waitrequest
);
	// ==========================================================
	// bus slave, one wait state per access
	logic          resp_r, go;
	logic [15:0]   div_r;
	logic [7:0]    cmd_r, txd_r, rxd_r;
	logic          nack_r, busy;
	i2crp_hstate_t st_r;

	assign waitrequest = (read || write) && !resp_r;
	assign busy        = (st_r != HS_IDLE);
	assign go          = write && resp_r && address == `I2CRP_A_CMD && !busy;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			resp_r   <= 1'b0;
			readdata <= 32'h00000000;
			div_r    <= 16'(`I2CRP_DIV_RST);
			cmd_r    <= 8'h00;
			txd_r    <= 8'h00;
		end else begin
			resp_r <= (read || write) && !resp_r;
			if (read && !resp_r) begin
				unique case (address)
					`I2CRP_A_STAT: readdata <= {16'h0000, rxd_r, 6'h00, nack_r, busy};
					`I2CRP_A_DIV:  readdata <= {16'h0000, div_r};
					default:       readdata <= 32'h00000000;
				endcase
			end
			// a command while busy is dropped
			if (go) begin
				cmd_r <= writedata[7:0];
				txd_r <= writedata[15:8];
			end
			if (write && resp_r && address == `I2CRP_A_DIV && writedata[15:0] != 16'h0000)
				div_r <= writedata[15:0];
		end
	end

	// ==========================================================
	// quarter tick divider
	logic [15:0]   cnt_r;
	logic          tick;

	assign tick = (cnt_r == div_r - 16'h0001);
	always_ff @(posedge clk) begin
		if (sys_rst || !busy || tick)
			cnt_r <= 16'h0000;
		else
			cnt_r <= cnt_r + 16'h0001;
	end

	// ==========================================================
	// bit engine
	logic          sda_s;
	logic [1:0]    q_r;
	logic [3:0]    bi_r;
	logic [8:0]    txs_r, rxs_r;
	logic          scl_r, sda_r;

	i2crp_sync #(.W(1), .INIT(1'b1)) u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.d       (bus.sda),
		.q       (sda_s)
	);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r   <= HS_IDLE;
			q_r    <= 2'h0;
			bi_r   <= 4'h0;
			txs_r  <= 9'h1ff;
			rxs_r  <= 9'h000;
			scl_r  <= 1'b1;
			sda_r  <= 1'b1;
			rxd_r  <= 8'h00;
			nack_r <= 1'b0;
		end else if (go) begin
			// read sends ones and its own ack bit; write expects the ack
			txs_r <= writedata[`I2CRP_CMD_READ] ? {8'hff, writedata[`I2CRP_CMD_NACK]}
			                                   : {writedata[15:8], 1'b1};
			bi_r  <= 4'h0;
			q_r   <= 2'h0;
			st_r  <= writedata[`I2CRP_CMD_START] ? HS_START : HS_BIT;
		end else if (tick) begin
			q_r <= q_r + 2'h1;
			unique case (st_r)
				HS_START: begin
					// same sequence serves a repeated start
					unique case (q_r)
						2'h0: sda_r <= 1'b1;
						2'h1: scl_r <= 1'b1;
						2'h2: sda_r <= 1'b0;
						2'h3: begin
							scl_r <= 1'b0;
							st_r  <= HS_BIT;
						end
					endcase
				end
				HS_BIT: begin
					unique case (q_r)
						2'h0: sda_r <= txs_r[8];
						2'h1: scl_r <= 1'b1;
						2'h2: rxs_r <= {rxs_r[7:0], sda_s};
						2'h3: begin
							scl_r <= 1'b0;
							txs_r <= {txs_r[7:0], 1'b1};
							bi_r  <= bi_r + 4'h1;
							if (bi_r == 4'h8) begin
								rxd_r  <= rxs_r[8:1];
								nack_r <= rxs_r[0];
								st_r   <= cmd_r[`I2CRP_CMD_STOP] ? HS_STOP : HS_IDLE;
							end
						end
					endcase
				end
				HS_STOP: begin
					unique case (q_r)
						2'h0: sda_r <= 1'b0;
						2'h1: scl_r <= 1'b1;
						2'h2: sda_r <= 1'b1;
						2'h3: st_r  <= HS_IDLE;
					endcase
				end
				default: ;
			endcase
		end
	end

	// open drain: drive low only
	assign bus.scl_m_o  = 1'b0;
	assign bus.scl_m_oe = !scl_r;
	assign bus.sda_m_o  = 1'b0;
	assign bus.sda_m_oe = !sda_r;
endmodule : i2crp_host
`default_nettype wire

// file: logic/i2crp_if.sv
`default_nettype none
interface i2crp_if;
	// open-drain drivers of both ends
	logic scl_m_o;
	logic scl_m_oe;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_s_o;
	logic sda_s_oe;
	// resolved wire levels, pulled up when nobody pulls low
	logic scl;
	logic sda;
	assign scl = !(scl_m_oe && !scl_m_o);
	assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
	modport dev (input scl, input sda, output sda_s_o, output sda_s_oe);
	modport host (input sda, output scl_m_o, output scl_m_oe, output sda_m_o, output sda_m_oe);
endinterface : i2crp_if
`default_nettype wire

// file: logic/i2crp_pkg.sv
`default_nettype none
package i2crp_pkg;
	// device byte phase
	typedef enum logic [2:0] {
		DP_IDLE, DP_ADDR, DP_OFFH, DP_OFFL, DP_WR, DP_RD, DP_IGN
	} i2crp_dphase_t;
	// controller bit engine
	typedef enum logic [1:0] {
		HS_IDLE, HS_START, HS_BIT, HS_STOP
	} i2crp_hstate_t;
endpackage : i2crp_pkg
`default_nettype wire

// file: logic/i2crp_regs.svh
`ifndef I2CRP_REGS_SVH
`define I2CRP_REGS_SVH
// ==========================================================
// device side constants
`define I2CRP_DEF_BASE    7'h58
`define I2CRP_PG_OFS_S    8'hfc
`define I2CRP_PG_OFS_L    16'hfffc
`define I2CRP_USER_BIT    15
`define I2CRP_WAIT_CAP    2'h3
// ==========================================================
// controller register map, byte addresses
`define I2CRP_A_CMD       4'h0
`define I2CRP_A_STAT      4'h4
`define I2CRP_A_DIV       4'h8
`define I2CRP_CMD_START   0
`define I2CRP_CMD_STOP    1
`define I2CRP_CMD_READ    2
`define I2CRP_CMD_NACK    3
`define I2CRP_STAT_BUSY   0
`define I2CRP_STAT_NACK   1
// ==========================================================
// timing: link clock is four quarter ticks of the system clock
`define I2CRP_CLK_HZ      40000000
`define I2CRP_SCL_HZ      1000000
`define I2CRP_DIV_RST     (`I2CRP_CLK_HZ / (4 * `I2CRP_SCL_HZ))
`endif

// file: logic/i2crp_sync.sv
`default_nettype none
module i2crp_sync #(
	parameter int              W    = 1,
	parameter logic [W-1:0]    INIT = '1
) (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          sys_rst,
	// asynchronous in, synchronous out
	input  wire logic [W-1:0]  d,
	output var  logic [W-1:0]  q
);
	logic [W-1:0] meta_r;
	// first stage feeds only the second
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta_r <= INIT;
			q      <= INIT;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule : i2crp_sync
`default_nettype wire

// file: tb/i2c_slave_register_port_bench.sv
`include "i2crp_regs.svh"
`default_nettype none
module i2c_slave_register_port_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0, sys_rst = 1'b1, cfg_done = 1'b0, lom = 1'b1;
	logic [1:0]  strap = 2'h0;
	logic        g2en = 1'b0, g2 = 1'b0, bload = 1'b0;
	logic [6:0]  bval = 7'h00, base = `I2CRP_DEF_BASE;
	logic [3:0]  address = 4'h0;
	logic        read = 1'b0, write = 1'b0, waitrequest, reg_wr, reg_rd, reg_commit;
	logic [31:0] writedata = 32'h0, readdata, rd, pv, page, seed = 32'ha3ae;
	logic [15:0] reg_addr;
	logic [7:0]  reg_wdata, reg_rdata = 8'h0;
	logic [7:0]  mem [65536], shd [65536], wq [$], rq [$];
	logic [23:0] stage [$], expq [$];
	logic [6:0]  dv;
	int          fails = 0, n_tests = 0;
	assign dv = {base[6:3], g2en ? g2 : base[2], strap};
	i2crp_if bus ();
	// ==========================================
	// clock and design
	always #12.5 clk = !clk;
	i2crp_dev u_i2crp_dev (.clk(clk), .sys_rst(sys_rst), .bus(bus.dev), .cfg_done(cfg_done),
		.cfg_base_load(bload), .cfg_base(bval), .long_offset_mode(lom), .gpio_strap_en(g2en),
		.strap_addr_bit_zero(strap[0]), .strap_addr_bit_one(strap[1]),
		.gpio_addr_bit_two(g2), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_commit(reg_commit), .port_page_select(page));
	i2crp_host u_i2crp_host (.clk(clk), .sys_rst(sys_rst), .bus(bus.host), .address(address),
		.read(read), .write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest));
	i2crp_checker u_i2crp_checker (.clk(clk), .sys_rst(sys_rst), .cfg_done(cfg_done),
		.dev_addr(dv), .scl(bus.scl),
		.sda(bus.sda), .sda_s_oe(bus.sda_s_oe));
	// register side: bytes staged, applied whole on commit
	always @(posedge clk) begin
		if (reg_rd)
			reg_rdata <= mem[reg_addr];
		if (reg_wr) begin
			check({reg_addr, reg_wdata}, expq.size() ? expq.pop_front() : 24'hffffff);
			stage.push_back({reg_addr, reg_wdata});
		end
		if (reg_commit) begin
			foreach (stage[j]) mem[stage[j][23:8]] = stage[j][7:0];
			stage.delete();
		end
	end
	// ==========================================
	// helpers
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	function automatic logic [7:0] nxt();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction : nxt
	// one bus cycle, held until waitrequest is seen low
	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		address   <= a;
		write     <= wr;
		read      <= !wr;
		writedata <= d;
		do @(posedge clk); while (waitrequest !== 1'b0);
		rd = readdata;
		write <= 1'b0;
		read  <= 1'b0;
	endtask : av
	// one byte on the link; flags start, stop, read, nack
	task automatic op(input logic [3:0] fl, input logic [7:0] w);
		av(1'b1, `I2CRP_A_CMD, {16'h0000, w, 4'h0, fl});
		do av(1'b0, `I2CRP_A_STAT, 32'h0); while (rd[`I2CRP_STAT_BUSY] === 1'b1);
	endtask : op
	// offset, queued data, then optional read after repeated start
	task automatic xfer(input logic [15:0] ofs, input int nr);
		logic [7:0] v;
		op(4'h1, {dv, 1'b0});
		check(rd[1], 1'b0);
		if (lom)
			op(4'h0, ofs[15:8]);
		op((wq.size() == 0 && nr == 0) ? 4'h2 : 4'h0, ofs[7:0]);
		while (wq.size() > 0) begin
			v = wq.pop_front();
			op((wq.size() == 0 && nr == 0) ? 4'h2 : 4'h0, v);
		end
		if (nr > 0)
			op(4'h1, {dv, 1'b1});
		for (int i = 0; i < nr; i++) begin
			op((i == nr - 1) ? 4'he : 4'h4, 8'h00);
			rq.push_back(rd[15:8]);
		end
	endtask : xfer
	task automatic setpg(input logic [15:0] ofs, input logic [31:0] p, input int n);
		for (int i = 0; i < n; i++) wq.push_back(p[8*i +: 8]);
		// page bytes go out in a single burst
		xfer(ofs, 0);
	endtask : setpg
	// random burst, read back through the pointer
	task automatic burst(input logic [15:0] ra, input int n);
		logic [7:0] v;
		for (int i = 0; i < n; i++) begin
			v = nxt();
			wq.push_back(v);
			expq.push_back({ra + 16'(i), v});
			shd[ra + 16'(i)] = v;
		end
		xfer(ra, 0);
		xfer(ra, n);
		for (int i = 0; i < n; i++) check(rq.pop_front(), shd[ra + 16'(i)]);
		check(expq.size(), 32'h0);
	endtask : burst
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up
	// watchdog, well beyond the expected run
	initial begin
		#2ms;
		fails++;
		wrap_up();
	end
	// ==========================================
	// main sequence
	initial begin
		for (int i = 0; i < 65536; i++) mem[i] = 8'(i);
		shd = mem;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk);
		op(4'h3, {dv, 1'b0});
		check(rd[1], 1'b1);
		cfg_done <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			// straps move only while the link is idle
			strap <= 2'(s);
			repeat (4) @(posedge clk);
			op(4'h3, {dv, 1'b0});
			check(rd[1], 1'b0);
			op(4'h3, {dv ^ 7'h01, 1'b0});
			check(rd[1], 1'b1);
			op(4'h3, {dv ^ 7'h20, 1'b0});
			check(rd[1], 1'b1);
		end
		$display("address tests done");
		pv = {nxt(), nxt(), nxt(), nxt()};
		setpg(16'hfffc, pv, 4);
		check(page, pv);
		// start offsets kept well clear of the page end
		burst({1'b1, 7'(nxt()), nxt() & 8'hef}, 4);
		wq.push_back(nxt());
		xfer(16'h1234, 1);
		check(rq.pop_front(), 8'h00);
		$display("long offset tests done");
		lom <= 1'b0;
		pv = {nxt(), nxt(), 1'b1, 7'(nxt()), nxt()};
		setpg(16'h00fc, pv, 4);
		check(page, pv);
		burst({pv[15:8], nxt() & 8'hef}, 3);
		setpg(16'h00fc, 32'h0, 2);
		check(page, pv);
		$display("short offset tests done");
		// quarter period of 25 clocks, the slower rate
		av(1'b1, `I2CRP_A_DIV, 32'h19);
		burst({pv[15:8], nxt() & 8'hef}, 2);
		av(1'b0, 4'hc, 32'h0);
		check(rd, 32'h0);
		$display("speed test done");
		// gpio level decides bit two from this reset on
		g2en    <= 1'b1;
		g2      <= 1'b1;
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk);
		check(page, 32'h0);
		op(4'h3, {dv, 1'b0});
		check(rd[1], 1'b0);
		op(4'h3, {dv ^ 7'h04, 1'b0});
		check(rd[1], 1'b1);
		// configuration loads a new base address
		bval  <= 7'h23;
		bload <= 1'b1;
		base  <= 7'h23;
		@(posedge clk);
		bload <= 1'b0;
		op(4'h3, {dv, 1'b0});
		check(rd[1], 1'b0);
		$display("reset test done");
		wrap_up();
	end
endmodule : i2c_slave_register_port_bench
`default_nettype wire

// file: tb/i2crp_checker.sv
`default_nettype none
// ==========================================
// serial link watcher
module i2crp_checker (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// device configuration, expected bus address
	input wire logic       cfg_done,
	input wire logic [6:0] dev_addr,
	// link wires
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_s_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       scl_r, sda_r, first_r, rw_r, sel_r, unsel_r, idle_r;
	logic [3:0] bit_r, low_r;
	logic [7:0] sh_r;
	logic       start, stop, rise, hit;
	// line events and address match
	assign start = scl && scl_r && sda_r && !sda;
	assign stop  = scl && scl_r && !sda_r && sda;
	assign rise  = scl && !scl_r;
	assign hit   = cfg_done && sh_r[7:1] == dev_addr;
	// edge history, lines idle high in reset
	always_ff @(posedge clk) begin
		scl_r <= sys_rst || scl;
		sda_r <= sys_rst || sda;
	end
	// age of the low phase, saturates
	always_ff @(posedge clk) begin
		if (scl)
			low_r <= 4'h0;
		else if (low_r != 4'hf)
			low_r <= low_r + 4'h1;
	end
	// frame tracker, restarts on start or stop
	always_ff @(posedge clk) begin
		if (sys_rst || stop || start) begin
			idle_r  <= sys_rst || stop;
			first_r <= !sys_rst && !stop;
			sel_r   <= 1'b0;
			unsel_r <= 1'b0;
			bit_r   <= 4'h0;
		end else if (rise) begin
			sh_r  <= {sh_r[6:0], sda};
			bit_r <= (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
			if (bit_r == 4'h8 && first_r) begin
				first_r <= 1'b0;
				rw_r    <= sh_r[0];
				sel_r   <= hit;
				unsel_r <= !hit;
			end
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	sequence s_addr_slot;
		rise && bit_r == 4'h8 && first_r;
	endsequence
	sequence s_data_slot;
		rise && bit_r == 4'h8 && !first_r && !idle_r;
	endsequence
	AST_ADDR_ACK: assert property (s_addr_slot ##0 hit |-> sda_s_oe)
		else $error("own address not acknowledged");
	AST_ADDR_NAK: assert property (s_addr_slot ##0 !hit |-> !sda_s_oe)
		else $error("foreign address acknowledged");
	AST_UNSEL: assert property (unsel_r |-> !sda_s_oe)
		else $error("data line driven while not selected");
	AST_IDLE: assert property (idle_r |-> !sda_s_oe)
		else $error("data line driven between frames");
	AST_CFG: assert property (!cfg_done |-> !sda_s_oe)
		else $error("data line driven before configuration");
	AST_WR_ACK: assert property (s_data_slot ##0 (sel_r && !rw_r) |-> sda_s_oe)
		else $error("written byte not acknowledged");
	AST_RD_REL: assert property (s_data_slot ##0 (sel_r && rw_r) |-> !sda_s_oe)
		else $error("ack slot of a read not released");
	AST_OE_TIME: assert property ($changed(sda_s_oe) |-> !scl && low_r >= 4'h2 && low_r <= 4'ha)
		else $error("data line changed outside the low phase window");
endmodule : i2crp_checker
`default_nettype wire
